// ==== ctw_top.sv ====
// ctw_top: top-off, wake-up, interrupt reminder/release and guard timer
// assumes the serial core gives byte writes/reads with a one-cycle strobe
// Operation
// - top-off charge lasts 0/30/45/60 minutes
// - wake-up interrupt period chosen from eight
// - wake-up timer runs only when enabled
// - release bit frees line, clears itself after
// - guard interrupt after 1/2/4/8 s when enabled
// - after guard, wait 200/500 ms then restore
`timescale 1ns/1ps
module ctw_top
   import ctw_pkg::*;
#(
   parameter logic [31:0] P_MS_DIV = CTW_MS_W // cycles per millisecond
)(
   // clock and reset
   input  wire logic       i_clk,
   input  wire logic       i_reset_n,
   // register port from serial core
   input  wire logic       i_reg_wr,
   input  wire logic       i_reg_rd,
   input  wire logic [7:0] i_reg_addr,
   input  wire logic [7:0] i_reg_wdata,
   output logic      [7:0] o_reg_rdata,
   // charger interface
   input  wire logic       i_end_of_charge,
   input  wire logic       i_irq_event,
   output logic            o_topoff_active,
   output logic            o_topoff_done,
   output logic            o_settings_restore,
   // interrupt line, active low open drain
   output logic            o_irq_oe,
   output logic            o_irq_pending
);
   // ************************************************************
   // registers and timers
   // ************************************************************
   logic [7:0]  ctl_q;          // timer_and_irq_control
   logic [7:0]  grd_q;          // watchdog_control
   logic        tick;           // one ms enable
   logic [31:0] topoff_ms_q;    // top-off elapsed
   logic        topoff_run_q;   // top-off counting
   logic [31:0] wake_ms_q;      // wake-up elapsed
   logic [31:0] guard_ms_q;     // guard elapsed
   logic [31:0] rel_ms_q;       // line-release elapsed
   logic        pend_q;         // interrupt raised, unserviced
   logic        rel_q;          // line being released
   logic        remind_q;       // a reminder already due in this hold
   logic [31:0] remind_ms_q;    // time since line asserted
   logic        wake_hit;
   logic        guard_hit;
   logic        restore_hit;
   logic        access;
   logic [31:0] topoff_lim;
   logic [31:0] wake_lim;
   logic [31:0] guard_lim;
   logic [31:0] restore_lim;
   typedef enum {CTW_G_IDLE, CTW_G_COUNT, CTW_G_WAIT} ctw_guard_type;
   ctw_guard_type g_st_q;
   logic        rel_done;       // release ends at this tick
   ctw_ms_tick #(.P_DIV(P_MS_DIV)) u_tick (
      .i_clk     (i_clk),
      .i_reset_n (i_reset_n),
      .o_tick    (tick)
   );
   assign rel_done = rel_q && tick && rel_ms_q + 32'h1 >= 32'(CTW_RELEASE_MS);
   // any valid access restarts the guard while it counts
   assign access = (i_reg_wr | i_reg_rd) &&
                   (i_reg_addr == CTW_ADDR_TIMER_IRQ ||
                    i_reg_addr == CTW_ADDR_GUARD);
   // ************************************************************
   // limit decode
   // ************************************************************
   always_comb begin
      case (ctl_q[CTW_TOPOFF_LSB +: 2])
         2'h1:    topoff_lim = 32'(CTW_TOPOFF_30_MS);
         2'h2:    topoff_lim = 32'(CTW_TOPOFF_45_MS);
         2'h3:    topoff_lim = 32'(CTW_TOPOFF_60_MS);
         default: topoff_lim = 32'h0;
      endcase
      // 4 s doubling for codes 0..4, 2 min doubling for 5..7
      if (ctl_q[CTW_WAKE_LSB +: 3] < 3'h5)
         wake_lim = 32'(CTW_WAKE_4S_MS) << ctl_q[CTW_WAKE_LSB +: 3];
      else
         wake_lim = 32'(CTW_WAKE_2M_MS) << (ctl_q[CTW_WAKE_LSB +: 3] - 3'h5);
      guard_lim = 32'(CTW_GUARD_1S_MS) << grd_q[CTW_TMO_LSB +: 2];
      restore_lim = grd_q[CTW_RESTORE] ? 32'(CTW_RESTORE_1_MS)
                                       : 32'(CTW_RESTORE_0_MS);
   end

   assign wake_hit    = tick && ctl_q[CTW_WAKE_EN] &&
                        wake_ms_q + 32'h1 >= wake_lim;
   assign guard_hit   = tick && g_st_q == CTW_G_COUNT && !access &&
                        guard_ms_q + 32'h1 >= guard_lim;
   assign restore_hit = tick && g_st_q == CTW_G_WAIT &&
                        guard_ms_q + 32'h1 >= restore_lim;
   // ************************************************************
   // register writes; restore returns settings to reset values
   // ************************************************************
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         ctl_q <= CTW_RST_TIMER_IRQ;
         grd_q <= CTW_RST_GUARD;
      end else if (restore_hit) begin
         ctl_q <= CTW_RST_TIMER_IRQ;
         grd_q <= CTW_RST_GUARD;
      end else begin
         if (i_reg_wr && i_reg_addr == CTW_ADDR_TIMER_IRQ)
            ctl_q <= {i_reg_wdata[7:1], i_reg_wdata[CTW_RELEASE] |
                      (ctl_q[CTW_RELEASE] & !rel_done)}; // set wins
         else if (rel_done)
            ctl_q[CTW_RELEASE] <= 1'b0; // self clear when done
         if (i_reg_wr && i_reg_addr == CTW_ADDR_GUARD)
            grd_q <= i_reg_wdata & CTW_GUARD_WMASK;
      end
   end

   // read data registered
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n)
         o_reg_rdata <= 8'h00;
      else if (i_reg_rd)
         o_reg_rdata <= i_reg_addr == CTW_ADDR_TIMER_IRQ ? ctl_q :
                        i_reg_addr == CTW_ADDR_GUARD ? grd_q : 8'h00;
   end

   // ************************************************************
   // top-off timer
   // ************************************************************
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         topoff_run_q  <= 1'b0;
         topoff_ms_q   <= 32'h0;
         o_topoff_done <= 1'b0;
      end else if (i_end_of_charge && !topoff_run_q && !o_topoff_done) begin
         topoff_run_q  <= topoff_lim != 32'h0; // zero minutes ends at once
         o_topoff_done <= topoff_lim == 32'h0;
         topoff_ms_q   <= 32'h0;
      end else if (!i_end_of_charge) begin
         topoff_run_q  <= 1'b0;
         o_topoff_done <= 1'b0;
      end else if (topoff_run_q && tick) begin
         topoff_ms_q <= topoff_ms_q + 32'h1;
         if (topoff_ms_q + 32'h1 >= topoff_lim) begin
            topoff_run_q  <= 1'b0;
            o_topoff_done <= 1'b1;
         end
      end
   end
   assign o_topoff_active = topoff_run_q;

   // ************************************************************
   // wake-up timer; stops and clears when disabled
   // ************************************************************
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n)
         wake_ms_q <= 32'h0;
      else if (!ctl_q[CTW_WAKE_EN] || wake_hit)
         wake_ms_q <= 32'h0;
      else if (tick)
         wake_ms_q <= wake_ms_q + 32'h1;
   end

   // ************************************************************
   // guard timer: count, interrupt, wait, restore
   // ************************************************************
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         g_st_q     <= CTW_G_IDLE;
         guard_ms_q <= 32'h0;
      end else if (!grd_q[CTW_GUARD_EN]) begin
         g_st_q     <= CTW_G_IDLE; // disable stops timer and restore
         guard_ms_q <= 32'h0;
      end else begin
         case (g_st_q)
            CTW_G_IDLE: begin
               g_st_q     <= CTW_G_COUNT;
               guard_ms_q <= 32'h0;
            end
            CTW_G_COUNT: begin
               if (access)
                  guard_ms_q <= 32'h0;
               else if (guard_hit) begin
                  g_st_q     <= CTW_G_WAIT;
                  guard_ms_q <= 32'h0;
               end else if (tick)
                  guard_ms_q <= guard_ms_q + 32'h1;
            end
            CTW_G_WAIT: begin
               if (restore_hit) begin
                  g_st_q     <= CTW_G_IDLE;
                  guard_ms_q <= 32'h0;
               end else if (tick)
                  guard_ms_q <= guard_ms_q + 32'h1;
            end
            default: g_st_q <= CTW_G_IDLE;
         endcase
      end
   end
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n)
         o_settings_restore <= 1'b0;
      else
         o_settings_restore <= restore_hit;
   end

   // ************************************************************
   // interrupt pending, cleared by a read (the host check)
   // set wins over the clear so no event is lost
   // ************************************************************
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n)
         pend_q <= 1'b0;
      else if (i_irq_event || wake_hit || guard_hit)
         pend_q <= 1'b1;
      else if (i_reg_rd)
         pend_q <= 1'b0;
   end
   assign o_irq_pending = pend_q;

   // ************************************************************
   // line release: software request or reminder
   // ************************************************************
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         rel_q       <= 1'b0;
         rel_ms_q    <= 32'h0;
         remind_ms_q <= 32'h0;
         remind_q    <= 1'b0;
      end else if (rel_q) begin
         if (tick) begin
            rel_ms_q <= rel_ms_q + 32'h1;
            if (rel_ms_q + 32'h1 >= 32'(CTW_RELEASE_MS))
               rel_q <= 1'b0; // line asserted again
         end
      end else if (ctl_q[CTW_RELEASE]) begin
         rel_q    <= 1'b1;
         rel_ms_q <= 32'h0;
      end else if (pend_q && ctl_q[CTW_REMIND] && tick) begin
         // reminder after a wake-period-scale wait of 4 s unserviced
         remind_ms_q <= remind_ms_q + 32'h1;
         if (remind_ms_q + 32'h1 >= 32'(CTW_WAKE_4S_MS)) begin
            rel_q       <= 1'b1;
            rel_ms_q    <= 32'h0;
            remind_ms_q <= 32'h0;
            remind_q    <= 1'b1;
         end
      end else if (!pend_q) begin
         remind_ms_q <= 32'h0;
         remind_q    <= 1'b0;
      end
   end
   assign o_irq_oe = pend_q && !rel_q; // drive low while pending, except during a release

   // ************************************************************
   // checks
   // ************************************************************
   chk_wake_disabled: assert property (@(posedge i_clk) disable iff
      (!i_reset_n) !ctl_q[CTW_WAKE_EN] |=> wake_ms_q == 32'h0)
      else $error("wake timer ran while disabled");
   chk_release_frees: assert property (@(posedge i_clk) disable iff
      (!i_reset_n) rel_q |-> !o_irq_oe)
      else $error("line driven during release");
   chk_release_start: assert property (@(posedge i_clk) disable iff
      (!i_reset_n) ctl_q[CTW_RELEASE] && !rel_q |=> rel_q)
      else $error("release request not started");
   chk_guard_wait: assert property (@(posedge i_clk) disable iff
      (!i_reset_n) guard_hit && grd_q[CTW_GUARD_EN] |=>
      g_st_q == CTW_G_WAIT)
      else $error("guard timeout did not enter wait");
   chk_guard_pend: assert property (@(posedge i_clk) disable iff
      (!i_reset_n) guard_hit |=> pend_q)
      else $error("guard timeout raised no interrupt");
   chk_restore_vals: assert property (@(posedge i_clk) disable iff
      (!i_reset_n) restore_hit |=> grd_q == CTW_RST_GUARD &&
      ctl_q == CTW_RST_TIMER_IRQ && o_settings_restore)
      else $error("settings not restored");
   chk_access_kick: assert property (@(posedge i_clk) disable iff
      (!i_reset_n) access && g_st_q == CTW_G_COUNT &&
      grd_q[CTW_GUARD_EN] |=> guard_ms_q == 32'h0)
      else $error("access did not restart guard");
   chk_topoff_zero: assert property (@(posedge i_clk) disable iff
      (!i_reset_n) i_end_of_charge && !topoff_run_q && !o_topoff_done &&
      topoff_lim == 32'h0 |=> o_topoff_done)
      else $error("zero top-off not immediate");
   chk_wake_pend: assert property (@(posedge i_clk) disable iff
      (!i_reset_n) wake_hit |=> pend_q)
      else $error("wake-up raised no interrupt");
   chk_remind_rel: assert property (@(posedge i_clk) disable iff
      (!i_reset_n) !ctl_q[CTW_REMIND] && !ctl_q[CTW_RELEASE] && !rel_q
      |=> !rel_q)
      else $error("release without request");
   cov_wake: cover property (@(posedge i_clk) wake_hit);
   cov_restore: cover property (@(posedge i_clk) restore_hit);
   cov_remind: cover property (@(posedge i_clk) remind_q && rel_q);
   cov_topoff: cover property (@(posedge i_clk) $rose(o_topoff_done));
endmodule

// ==== ctw_pkg.sv ====
// ctw_pkg: shared constants for the charger timer and irq housekeeping block
// assumes a 100 MHz clock and a simple byte register port from the serial core
package ctw_pkg;
   // ************************************************************
   // register map
   // ************************************************************
   localparam logic [7:0] CTW_ADDR_TIMER_IRQ = 8'h24; // timer_and_irq_control
   localparam logic [7:0] CTW_ADDR_GUARD     = 8'h25; // watchdog_control
   localparam logic [7:0] CTW_RST_TIMER_IRQ  = 8'h00;
   localparam logic [7:0] CTW_RST_GUARD      = 8'h13;
   localparam logic [7:0] CTW_GUARD_WMASK    = 8'h93; // writable bits
   // field positions in timer_and_irq_control
   localparam int CTW_TOPOFF_LSB = 6;
   localparam int CTW_WAKE_LSB   = 3;
   localparam int CTW_WAKE_EN    = 2;
   localparam int CTW_REMIND     = 1;
   localparam int CTW_RELEASE    = 0;
   // field positions in watchdog_control
   localparam int CTW_GUARD_EN   = 7;
   localparam int CTW_RESTORE    = 4;
   localparam int CTW_TMO_LSB    = 0;
   // ************************************************************
   // time base
   // ************************************************************
   localparam int CTW_CLK_MHZ    = 100;
   localparam int CTW_MS_NS      = 1000000;
   localparam int CTW_CLK_NS     = 1000 / CTW_CLK_MHZ;
   localparam int CTW_MS_CYCLES  = CTW_MS_NS / CTW_CLK_NS;
   // periods in ms
   localparam int CTW_TOPOFF_30_MS  = 30 * 60000;
   localparam int CTW_TOPOFF_45_MS  = 45 * 60000;
   localparam int CTW_TOPOFF_60_MS  = 60 * 60000;
   localparam int CTW_WAKE_4S_MS    = 4000;    // doubles per code up to 64 s
   localparam int CTW_WAKE_2M_MS    = 120000;  // codes 5..7 double from 2 min
   localparam int CTW_GUARD_1S_MS   = 1000;    // doubles per code up to 8 s
   localparam int CTW_RESTORE_0_MS  = 200;
   localparam int CTW_RESTORE_1_MS  = 500;
   localparam int CTW_RELEASE_MS    = 1;       // length of a line release
   localparam logic [31:0] CTW_MS_W = 32'(CTW_MS_CYCLES);
endpackage

// ==== ctw_ms_tick.sv ====
// ctw_ms_tick: divider giving a one-cycle enable each millisecond
// assumes the single system clock; the period is a parameter for simulation
`timescale 1ns/1ps
module ctw_ms_tick
   import ctw_pkg::*;
#(
   parameter logic [31:0] P_DIV = CTW_MS_W
)(
   // clock and reset
   input  wire logic i_clk,
   input  wire logic i_reset_n,
   // tick out
   output logic      o_tick
);
   logic [31:0] cnt_q; // cycles inside the current millisecond

   // ************************************************************
   // free running divider
   // ************************************************************
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         cnt_q  <= 32'h0;
         o_tick <= 1'b0;
      end else if (cnt_q >= P_DIV - 32'h1) begin
         cnt_q  <= 32'h0;
         o_tick <= 1'b1;
      end else begin
         cnt_q  <= cnt_q + 32'h1;
         o_tick <= 1'b0;
      end
   end
endmodule

// ==== ctw_host.sv ====
// ctw_host: host model on the register port, plus the irq pin wire
// assumes the single system clock; bus changes land 1 ns after a rise
`timescale 1ns/1ps
module ctw_host (
   // clock, read data and irq drive back from the block
   input  wire logic       i_clk,
   input  wire logic [7:0] i_reg_rdata,
   input  wire logic       i_irq_oe,
   // register strobes and bus
   output logic            o_reg_wr,
   output logic            o_reg_rd,
   output logic      [7:0] o_reg_addr,
   output logic      [7:0] o_reg_wdata,
   // irq wire level seen by the host
   output logic            o_irq_pin
);
   // ****************************************************
   // pin and bus idle
   // ****************************************************
   // open drain with pull-up: released line reads high
   assign o_irq_pin = i_irq_oe ? 1'b0 : 1'b1;
   // idle bus shows a junk pattern, not the last value
   initial begin
      o_reg_wr    = 1'b0;
      o_reg_rd    = 1'b0;
      o_reg_addr  = 8'h5a;
      o_reg_wdata = 8'ha5;
   end
   // one byte write; an access to one of the two mapped places also restarts the guard while it counts
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clk);
      #1;
      o_reg_wr    = 1'b1;
      o_reg_addr  = a;
      o_reg_wdata = d;
      @(posedge i_clk);
      #1;
      o_reg_wr    = 1'b0;
      o_reg_addr  = ~a;
      o_reg_wdata = ~d;
   endtask
   // one byte read; data held from the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge i_clk);
      #1;
      o_reg_rd   = 1'b1;
      o_reg_addr = a;
      @(posedge i_clk);
      #1;
      o_reg_rd   = 1'b0;
      o_reg_addr = ~a;
      @(posedge i_clk);
      #1;
      d = i_reg_rdata;
   endtask
endmodule

// ==== tb.sv ====
// tb: self-checking bench for ctw_top with a shortened millisecond
// assumes ctw_host drives the register port; 1 ms is DIV cycles here
`timescale 1ns/1ps
module tb;
   import ctw_pkg::*;
   // ****************************************************
   // signals
   // ****************************************************
   localparam logic [31:0] DIV = 32'h2; // short ms keeps the run small
   logic       clk;
   logic       rst_n;
   logic       eoc;        // end of charge level
   logic       evt;        // external irq source
   logic       wr, rd, oe, pend, restore, tact, tdone, pin;
   logic [7:0] addr, wdata, rdata;
   int         error_cnt = 0;
   int         n_checks = 0;
   int         n;
   ctw_top #(.P_MS_DIV(DIV)) ctw_top_i (
      .i_clk(clk), .i_reset_n(rst_n), .i_reg_wr(wr), .i_reg_rd(rd),
      .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
      .i_end_of_charge(eoc), .i_irq_event(evt), .o_topoff_active(tact),
      .o_topoff_done(tdone), .o_settings_restore(restore),
      .o_irq_oe(oe), .o_irq_pending(pend));
   ctw_host ctw_host_i (
      .i_clk(clk), .i_reg_rdata(rdata), .i_irq_oe(oe), .o_reg_wr(wr),
      .o_reg_rd(rd), .o_reg_addr(addr), .o_reg_wdata(wdata),
      .o_irq_pin(pin));
   // ****************************************************
   // helpers
   // ****************************************************
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task final_report;
      if (error_cnt == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task check(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // watched conditions, picked by number to share one wait loop
   function automatic logic sig(input int s);
      case (s)
         0: return pend;
         1: return ~pin;
         2: return restore;
         3: return pin;
         4: return tdone;
         5: return ~tdone;
         default: return tact;
      endcase
   endfunction
   // bounded wait; running out is a mismatch and ends the run
   task automatic wait_for(input int s, input int max, output int c);
      c = 0;
      while (sig(s) !== 1'b1) begin
         if (c >= max) begin
            check(8'h00, 8'h01);
            final_report;
         end
         @(posedge clk);
         #1;
         c++;
      end
   endtask
   // tick granularity makes the first ms partial, so allow slack
   task automatic in_range(input int c, input int t);
      check(8'(c >= t - 6 && c <= t + 6), 8'h01);
   endtask
   task automatic quiet(input int s, input int c);
      logic bad;
      bad = 1'b0;
      repeat (c) begin
         @(posedge clk);
         #1;
         if (sig(s) === 1'b1) bad = 1'b1;
      end
      check(8'(bad), 8'h00);
   endtask
   task automatic pulse;
      @(posedge clk);
      #1;
      evt = 1'b1;
      @(posedge clk);
      #1;
      evt = 1'b0;
   endtask
   // ****************************************************
   // scenarios
   // ****************************************************
   task automatic t_regs;
      logic [7:0] d;
      ctw_host_i.rd(CTW_ADDR_TIMER_IRQ, d);
      check(d, CTW_RST_TIMER_IRQ);
      ctw_host_i.rd(CTW_ADDR_GUARD, d);
      check(d, CTW_RST_GUARD);
      ctw_host_i.rd(8'h30, d); // unmapped place reads as zero
      check(d, 8'h00);
   endtask
   task automatic t_release;
      logic [7:0] d;
      pulse();
      wait_for(0, 3, n);
      ctw_host_i.wr(8'h24, 8'h01);
      wait_for(3, 6, n);
      wait_for(1, 2 * DIV + 6, n);
      ctw_host_i.rd(8'h24, d);
      check(d, 8'h00);
      check(8'(pend), 8'h00);
   endtask
   task automatic t_remind;
      logic [7:0] d;
      ctw_host_i.wr(8'h24, 8'h02);
      pulse();
      wait_for(0, 3, n);
      wait_for(3, 4000 * DIV + 8, n);
      in_range(n, 4000 * DIV);
      wait_for(1, 2 * DIV + 6, n);
      ctw_host_i.rd(8'h24, d);
      check(d, 8'h02);
      ctw_host_i.wr(8'h24, 8'h00);
   endtask
   task automatic t_wake;
      logic [7:0] d;
      for (int k = 0; k < 2; k++) begin
         ctw_host_i.wr(8'h24, 8'h00);
         ctw_host_i.wr(8'h24, 8'h04 | 8'(k << 3));
         wait_for(0, (4000 << k) * DIV + 8, n);
         in_range(n, (4000 << k) * DIV);
         ctw_host_i.rd(8'h24, d);
      end
      ctw_host_i.wr(8'h24, 8'h00);
      quiet(0, 8200);
   endtask
   task automatic t_topoff;
      @(posedge clk);
      #1;
      eoc = 1'b1;
      wait_for(4, 6, n);
      eoc = 1'b0;
      wait_for(5, 4, n);
      ctw_host_i.wr(8'h24, 8'h40);
      eoc = 1'b1;
      wait_for(6, 8, n);
      quiet(4, 2000);
      eoc = 1'b0;
   endtask
   task automatic t_guard;
      logic [7:0] d;
      ctw_host_i.wr(8'h25, 8'hff);
      ctw_host_i.rd(8'h25, d);
      check(d, CTW_GUARD_WMASK);
      for (int k = 0; k < 2; k++) begin
         ctw_host_i.wr(8'h24, 8'h20);
         ctw_host_i.wr(8'h25, k ? 8'h90 : 8'h80);
         wait_for(0, 1000 * DIV + 8, n);
         in_range(n, 1000 * DIV);
         wait_for(2, 500 * DIV + 8, n);
         in_range(n, (k ? 500 : 200) * DIV);
         ctw_host_i.rd(8'h24, d);
         check(d, CTW_RST_TIMER_IRQ);
         ctw_host_i.rd(8'h25, d);
         check(d, CTW_RST_GUARD);
      end
      ctw_host_i.wr(8'h25, 8'h80);
      repeat (3) begin
         quiet(0, 1500);
         ctw_host_i.rd(8'h25, d);
      end
      ctw_host_i.wr(8'h25, 8'h00);
      quiet(0, 2200);
   endtask
   // ****************************************************
   // main sequence
   // ****************************************************
   initial begin
      rst_n = 1'b0;
      eoc   = 1'b0;
      evt   = 1'b0;
      repeat (2) @(posedge clk);
      #1;
      rst_n = 1'b1;
      t_regs();
      t_release();
      t_remind();
      t_wake();
      t_topoff();
      t_guard();
      final_report;
   end
endmodule
